// *** rtl/gdci_pkg.sv ***
/*
 * Shared types and constants for the demonstration-board command interpreter.
 * Assumes a byte-wide receive and transmit stream from a serial bridge.
 */
package gdci_pkg;

    // -----------------------------------------------------------------
    // Character codes
    // -----------------------------------------------------------------
    localparam logic [7:0] CH_STAR = 8'h2a;  // Command prefix.
    localparam logic [7:0] CH_LF = 8'h0a;    // Line terminator.
    localparam logic [7:0] CH_CR = 8'h0d;    // Carriage return, ignored in a line.
    localparam logic [7:0] CH_HDR0 = 8'h73;  // First frame header byte.
    localparam logic [7:0] CH_HDR1 = 8'h74;  // Second frame header byte.
    localparam logic [7:0] CH_PAD = 8'h00;   // Padding byte value.
    localparam logic [7:0] CH_ZERO = 8'h30;  // Decimal digit zero.
    localparam logic [7:0] CH_EQ = 8'h3d;    // Equals sign in text lines.
    localparam int SW_BIT = 0;               // Position of the button in the status byte.

    // -----------------------------------------------------------------
    // Line buffer and sizes
    // -----------------------------------------------------------------
    localparam int LINE_MAX = 8;             // Longest command body kept.
    localparam int NUM_SAMPLES = 5;          // Samples per frame.
    localparam int FRAME_LEN = 9;            // Bytes per binary frame.
    localparam int TEXT_LEN = 8;             // One more than the bytes per text line.
    localparam int REPLY_MAX = 16;           // Longest identity reply.

    // -----------------------------------------------------------------
    // Decoded commands
    // -----------------------------------------------------------------
    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_START,
        CMD_DEBUG,
        CMD_STOP,
        CMD_ZON,
        CMD_ZOFF,
        CMD_DEV,
        CMD_VER
    } gdci_cmd_t;

    // One set of converter samples, in frame order.
    typedef struct packed {
        logic [7:0] ref_volt;               // Reference voltage.
        logic [7:0] channel_two_amplified;  // Amplified channel two.
        logic [7:0] channel_two_plain;      // Unamplified channel two.
        logic [7:0] channel_one_amplified;  // Amplified channel one.
        logic [7:0] channel_one_plain;      // Unamplified channel one.
    } gdci_samples_t;

    // A byte stream beat.
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } gdci_byte_t;

endpackage : gdci_pkg

// *** rtl/gdci_dec3.sv ***
/*
 * Converts an 8-bit value into three ASCII decimal digits.
 * Assumes a purely combinational use inside the same clock domain.
 */
`timescale 1ns/100ps
`default_nettype none
module gdci_dec3 (
    input wire logic [7:0] value,
    output logic [23:0] digits
);
    import gdci_pkg::*;

    // -----------------------------------------------------------------
    // Digit split
    // -----------------------------------------------------------------
    logic [7:0] hund; // Hundreds digit.
    logic [7:0] tens; // Tens digit.
    logic [7:0] ones; // Units digit.

    // Divide out hundreds, tens and units of the raw result.
    always_comb begin
        hund = value / 8'd100;
        tens = (value % 8'd100) / 8'd10;
        ones = value % 8'd10;
        digits = {CH_ZERO + hund, CH_ZERO + tens, CH_ZERO + ones};
    end

endmodule : gdci_dec3
`default_nettype wire

// *** rtl/gdci_top.sv ***
/*
 * Command interpreter: parses star-prefixed text lines, switches the
 * sensor lines between isolated and driven, and streams samples.
 * Assumes byte streams from a serial bridge on the same clock, and sensor,
 * button and converter inputs that arrive from outside the clock domain.
 */
// Operation
// - Binary frames start with s then t
// - Five samples follow in fixed order
// - One zero pad byte precedes status
// - Status bit zero shows button two held
// - Start command streams frames until stop
// - Debug streams reference and outputs as text
// - Text values are raw decimal converter results
// - Stop ends binary or text streaming
// - Isolate command releases sensor lines
// - Leave-isolation command drives sensor lines again
// - Lines start isolated after reset
// - Mode and identity commands work in both modes
// - Name query replies with part string
// - Version query replies tag and version
`timescale 1ns/100ps
`default_nettype none
module gdci_top #(
    parameter int LINE_W = 4,                                 // Sensor interface lines.
    // Arbitrary part name string, left padded with NUL bytes.
    parameter logic [8*gdci_pkg::REPLY_MAX-1:0] PART_NAME =
        (8*gdci_pkg::REPLY_MAX)'("PARTNAME-A\n"),
    // Arbitrary product tag and version string.
    parameter logic [8*gdci_pkg::REPLY_MAX-1:0] FW_VERSION =
        (8*gdci_pkg::REPLY_MAX)'("FWTAG 0.01\n")
) (
    input wire logic mclk,
    input wire logic srst,
    input wire gdci_pkg::gdci_byte_t rx,
    input wire logic tx_ready,
    output var gdci_pkg::gdci_byte_t tx,
    input wire logic sample_strobe,
    input wire gdci_pkg::gdci_samples_t samples,
    input wire logic user_button_two,
    input wire logic [LINE_W-1:0] sensor_line_out,
    output logic [LINE_W-1:0] sensor_line_oe,
    output logic digital_working_mode
);
    import gdci_pkg::*;

    // -----------------------------------------------------------------
    // Input synchronisers
    // -----------------------------------------------------------------
    logic [1:0] btn_sync;  // Button synchroniser chain.
    logic [2:0] stb_sync;  // Sample strobe chain with edge history.

    // Two flops for the button; strobe edge taken past the second flop.
    always_ff @(posedge mclk) begin
        if (srst) begin
            btn_sync <= 2'h0;
            stb_sync <= 3'h0;
        end else begin
            btn_sync <= {btn_sync[0], user_button_two};
            stb_sync <= {stb_sync[1:0], sample_strobe};
        end
    end

    logic stb_rise;  // New converter set ready.
    assign stb_rise = stb_sync[1] & ~stb_sync[2];

    gdci_samples_t smp_s1; // First capture stage of samples.
    gdci_samples_t smp;    // Samples held steady for a frame.

    // Samples are stable around the strobe; capture twice, latch on edge.
    always_ff @(posedge mclk) begin
        if (srst) begin
            smp_s1 <= '0;
            smp <= '0;
        end else begin
            smp_s1 <= samples;
            if (stb_rise) begin
                smp <= smp_s1;
            end
        end
    end

    // -----------------------------------------------------------------
    // Line collector and decoder
    // -----------------------------------------------------------------
    logic [7:0] line_buf [LINE_MAX];  // Received command body.
    logic [3:0] line_len;             // Characters stored.
    logic line_star;                  // Line began with a star.
    logic line_over;                  // Line ran past the buffer or did not open with a star.

    // Matches the buffered body against an n-character text, length included.
    function automatic logic body_is(input logic [8*LINE_MAX-1:0] txt, input int n);
        logic ok;
        ok = (line_len == 4'(n));
        for (int i = 0; i < LINE_MAX; i++) begin
            if (i < n && line_buf[i] != txt[8*(n-1-i) +: 8]) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction : body_is

    gdci_cmd_t cmd;  // Command decoded at line end.

    // Decode on line feed; anything else stays CMD_NONE.
    always_comb begin
        cmd = CMD_NONE;
        if (rx.valid && rx.data == CH_LF && line_star && !line_over) begin
            if (body_is(64'("start"), 5)) begin
                cmd = CMD_START;
            end else if (body_is(64'("debug"), 5)) begin
                cmd = CMD_DEBUG;
            end else if (body_is(64'("stop"), 4)) begin
                cmd = CMD_STOP;
            end else if (body_is(64'("Zon"), 3)) begin
                cmd = CMD_ZON;
            end else if (body_is(64'("Zoff"), 4)) begin
                cmd = CMD_ZOFF;
            end else if (body_is(64'("dev"), 3)) begin
                cmd = CMD_DEV;
            end else if (body_is(64'("ver"), 3)) begin
                cmd = CMD_VER;
            end
        end
    end

    logic [3:0] next_line_len;
    logic next_line_star;
    logic next_line_over;

    // Collect characters after the star until the line feed.
    always_comb begin
        next_line_len = line_len;
        next_line_star = line_star;
        next_line_over = line_over;
        if (rx.valid) begin
            if (rx.data == CH_LF) begin
                next_line_len = 4'h0;
                next_line_star = 1'b0;
                next_line_over = 1'b0;
            end else if (rx.data == CH_CR) begin
                next_line_len = line_len;
            end else if (!line_star) begin
                // Only a star as the very first character opens a command line.
                next_line_star = (rx.data == CH_STAR) && !line_over;
                next_line_over = !next_line_star;
            end else if (line_len == 4'(LINE_MAX)) begin
                next_line_over = 1'b1;
            end else begin
                next_line_len = line_len + 4'h1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            line_len <= 4'h0;
            line_star <= 1'b0;
            line_over <= 1'b0;
        end else begin
            line_len <= next_line_len;
            line_star <= next_line_star;
            line_over <= next_line_over;
            if (rx.valid && line_star && rx.data != CH_LF && rx.data != CH_CR
                && line_len < 4'(LINE_MAX)) begin
                line_buf[line_len[2:0]] <= rx.data;
            end
        end
    end

    // -----------------------------------------------------------------
    // Mode and session control
    // -----------------------------------------------------------------
    typedef enum logic [1:0] {SES_IDLE, SES_BIN, SES_TEXT} gdci_ses_t;
    typedef enum logic [1:0] {TX_IDLE, TX_FRAME, TX_TEXT, TX_REPLY} gdci_tx_t;
    gdci_tx_t tx_state, next_tx_state;  // Transmitter state, read here for replies.
    gdci_ses_t ses, next_ses;  // Acquisition session.
    logic next_dwm;            // Next digital mode flag.
    logic [1:0] pend, next_pend; // Pending reply: 1 name, 2 version.

    // Commands steer the mode and session; unknown lines change nothing.
    always_comb begin
        next_ses = ses;
        next_dwm = digital_working_mode;
        // A reply stays pending until the transmitter really takes it.
        next_pend = (tx_state == TX_IDLE && next_tx_state == TX_REPLY) ? 2'h0 : pend;
        case (cmd)
            CMD_START: next_ses = SES_BIN;
            CMD_DEBUG: next_ses = SES_TEXT;
            CMD_STOP: next_ses = SES_IDLE;
            CMD_ZON: next_dwm = 1'b0;
            CMD_ZOFF: next_dwm = 1'b1;
            CMD_DEV: next_pend = 2'h1;
            CMD_VER: next_pend = 2'h2;
            default: next_ses = ses;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            ses <= SES_IDLE;
            digital_working_mode <= 1'b0;
            sensor_line_oe <= '0;
            pend <= 2'h0;
        end else begin
            ses <= next_ses;
            digital_working_mode <= next_dwm;
            sensor_line_oe <= {LINE_W{next_dwm}};
            pend <= next_pend;
        end
    end

    // -----------------------------------------------------------------
    // Transmitter
    // -----------------------------------------------------------------
    logic [4:0] idx, next_idx;          // Byte index within message.
    logic [2:0] chan, next_chan;        // Text channel being printed.
    logic [8*REPLY_MAX-1:0] reply, next_reply; // Reply text being sent.
    gdci_byte_t next_tx;
    logic [23:0] dec;                   // Decimal digits of current channel.
    logic [7:0] cur;                    // Sample chosen for text.

    // Pick the text channel: reference first, then the four outputs.
    always_comb begin
        case (chan)
            3'h0: cur = smp.ref_volt;
            3'h1: cur = smp.channel_two_amplified;
            3'h2: cur = smp.channel_two_plain;
            3'h3: cur = smp.channel_one_amplified;
            default: cur = smp.channel_one_plain;
        endcase
    end

    gdci_dec3 u_dec (
        .value(cur),
        .digits(dec)
    );

    // Sends one byte per accepted beat; a new sample set starts a frame only if the transmitter is idle and no reply is pending.
    always_comb begin
        next_tx_state = tx_state;
        next_idx = idx;
        next_chan = chan;
        next_reply = reply;
        next_tx = tx;
        if (tx.valid && tx_ready) begin
            next_tx.valid = 1'b0;
        end
        if (!next_tx.valid) begin
            case (tx_state)
                TX_IDLE: begin
                    if (pend == 2'h1) begin
                        next_tx_state = TX_REPLY;
                        next_reply = PART_NAME;
                    end else if (pend == 2'h2) begin
                        next_tx_state = TX_REPLY;
                        next_reply = FW_VERSION;
                    end else if (stb_rise && ses == SES_BIN) begin
                        next_tx_state = TX_FRAME;
                    end else if (stb_rise && ses == SES_TEXT) begin
                        next_tx_state = TX_TEXT;
                    end
                    next_idx = 5'h0;
                    next_chan = 3'h0;
                end
                TX_FRAME: begin
                    next_tx.valid = 1'b1;
                    case (idx)
                        5'h0: next_tx.data = CH_HDR0;
                        5'h1: next_tx.data = CH_HDR1;
                        5'h2: next_tx.data = smp.ref_volt;
                        5'h3: next_tx.data = smp.channel_two_amplified;
                        5'h4: next_tx.data = smp.channel_two_plain;
                        5'h5: next_tx.data = smp.channel_one_amplified;
                        5'h6: next_tx.data = smp.channel_one_plain;
                        5'h7: next_tx.data = CH_PAD;
                        default: next_tx.data = 8'(btn_sync[1]) << SW_BIT;
                    endcase
                    next_idx = idx + 5'h1;
                    if (idx == 5'(FRAME_LEN - 1)) begin
                        next_tx_state = TX_IDLE;
                    end
                end
                TX_TEXT: begin
                    // Line: tag letter, '=', three digits, CR LF; seven bytes in all.
                    next_tx.valid = 1'b1;
                    case (idx)
                        5'h0: next_tx.data = (chan == 3'h0) ? 8'h52 : 8'h4f;
                        5'h1: next_tx.data = CH_EQ;
                        5'h2: next_tx.data = dec[23:16];
                        5'h3: next_tx.data = dec[15:8];
                        5'h4: next_tx.data = dec[7:0];
                        5'h5: next_tx.data = CH_CR;
                        default: next_tx.data = CH_LF;
                    endcase
                    next_idx = idx + 5'h1;
                    if (idx == 5'(TEXT_LEN - 2)) begin
                        next_idx = 5'h0;
                        next_chan = chan + 3'h1;
                        if (chan == 3'(NUM_SAMPLES - 1)) begin
                            next_tx_state = TX_IDLE;
                        end
                    end
                end
                default: begin
                    next_tx.data = reply[8*REPLY_MAX-1 -: 8];
                    next_tx.valid = (next_tx.data != 8'h00);
                    next_reply = {reply[8*REPLY_MAX-9:0], 8'h00};
                    next_idx = idx + 5'h1;
                    if (idx == 5'(REPLY_MAX - 1)) begin
                        next_tx_state = TX_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            tx_state <= TX_IDLE;
            idx <= 5'h0;
            chan <= 3'h0;
            reply <= '0;
            tx <= '0;
        end else begin
            tx_state <= next_tx_state;
            idx <= next_idx;
            chan <= next_chan;
            reply <= next_reply;
            tx <= next_tx;
        end
    end

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    sequence s_start_cmd;
        cmd == CMD_START;
    endsequence

    a_reset_isolated: assert property (@(posedge mclk) $fell(srst) |-> sensor_line_oe == '0)
        else $error("Lines not isolated after reset");
    a_zoff_drives: assert property (@(posedge mclk) disable iff (srst)
        cmd == CMD_ZOFF |=> digital_working_mode && sensor_line_oe == '1)
        else $error("Lines not driven after leave command");
    a_zon_isolates: assert property (@(posedge mclk) disable iff (srst)
        cmd == CMD_ZON |=> !digital_working_mode && sensor_line_oe == '0)
        else $error("Lines not released after isolate command");
    a_start_binary: assert property (@(posedge mclk) disable iff (srst)
        s_start_cmd |=> ses == SES_BIN)
        else $error("Start did not begin binary session");
    a_stop_idle: assert property (@(posedge mclk) disable iff (srst)
        cmd == CMD_STOP |=> ses == SES_IDLE)
        else $error("Stop did not end session");
    a_frame_header: assert property (@(posedge mclk) disable iff (srst)
        tx_state == TX_FRAME && idx == 5'h0 && !tx.valid |=> tx.valid && tx.data == CH_HDR0)
        else $error("Frame header wrong");
    a_pad_zero: assert property (@(posedge mclk) disable iff (srst)
        tx_state == TX_FRAME && idx == 5'h7 && (!tx.valid || tx_ready)
        |=> tx.valid && tx.data == 8'h00)
        else $error("Pad byte not zero");
    a_unknown_keeps: assert property (@(posedge mclk) disable iff (srst)
        rx.valid && rx.data == CH_LF && cmd == CMD_NONE |=> $stable(digital_working_mode))
        else $error("Unknown line changed mode");

endmodule : gdci_top
`default_nettype wire

// *** verification/gdci_host.sv ***
/*
 * Host-side model: types command lines into the interpreter and accepts the
 * bytes it sends back, either at once or with a stall every other cycle.
 * Assumes the interpreter's clock and its byte stream types from the package.
 */
`timescale 1ns/100ps
`default_nettype none
module gdci_host (
    input wire logic mclk,
    input wire logic slow,
    input wire gdci_pkg::gdci_byte_t tx,
    output var gdci_pkg::gdci_byte_t rx,
    output logic tx_ready
);
    import gdci_pkg::*;
    // -----------------------------------------------------------------
    // Receive side and stall pattern
    // -----------------------------------------------------------------
    logic [7:0] got[$];  // Bytes accepted from the interpreter.
    logic [7:0] last_b;  // Last byte typed, used to poison the idle line.
    logic phase;         // Toggles every cycle to make the stall pattern.
    initial begin
        rx = '0;
        last_b = 8'h00;
        phase = 1'b0;
        tx_ready = 1'b0;
    end
    // Ready changes only off the sampling edge; slow mode halves throughput.
    always @(negedge mclk) begin
        phase <= ~phase;
        tx_ready <= slow ? phase : 1'b1;
    end
    // Collect each byte at the edge where it is handed over.
    always @(posedge mclk) begin
        if (tx.valid && tx_ready) begin
            got.push_back(tx.data);
        end
    end
    // -----------------------------------------------------------------
    // Command typing: one 8-bit byte per valid pulse, line-feed ends it
    // -----------------------------------------------------------------
    task automatic send_line(input string s);
        for (int i = 0; i <= s.len(); i++) begin
            @(negedge mclk);
            rx.valid = 1'b1;
            rx.data = (i == s.len()) ? CH_LF : s[i];
            last_b = rx.data;
            @(negedge mclk);
            // An idle line shows garbage, not the last byte.
            rx.valid = 1'b0;
            rx.data = ~last_b;
        end
        @(negedge mclk);
    endtask : send_line
endmodule : gdci_host
`default_nettype wire

// *** verification/tb_top.sv ***
/*
 * Self-checking bench for the command interpreter: mode switching, binary
 * frames, text streaming, stop, discarded lines and identity replies.
 * Assumes the host model in gdci_host.sv and a 100 MHz clock.
 */
`timescale 1ns/100ps
`default_nettype none
`define CHK(act, exp) begin num_checks++; if ((act) !== (exp)) begin n_fail++; \
    $display("wrong value at %0t: got %h expected %h", $time, act, exp); end end
module tb_top;
    import gdci_pkg::*;
    // -----------------------------------------------------------------
    // Stimulus and wiring
    // -----------------------------------------------------------------
    localparam logic [8*REPLY_MAX-1:0] NAME_S = "PARTNAME-A\n";  // Arbitrary.
    localparam logic [8*REPLY_MAX-1:0] VER_S = "FWTAG 0.01\n";   // Arbitrary.
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic slow = 1'b0;          // Host stalls every other cycle when set.
    logic sample_strobe = 1'b0;
    logic user_button_two = 1'b0;
    gdci_samples_t samples = '0;
    gdci_byte_t rx;
    gdci_byte_t tx;
    logic tx_ready;
    logic [3:0] sensor_line_oe;
    logic digital_working_mode;
    int n_fail = 0;
    int num_checks = 0;
    int cyc = 0;
    always #5 mclk = ~mclk;
    gdci_top #(.LINE_W(4), .PART_NAME(NAME_S), .FW_VERSION(VER_S)) uut (
        .mclk(mclk), .srst(srst), .rx(rx), .tx_ready(tx_ready), .tx(tx),
        .sample_strobe(sample_strobe), .samples(samples),
        .user_button_two(user_button_two), .sensor_line_out(4'h0),
        .sensor_line_oe(sensor_line_oe), .digital_working_mode(digital_working_mode));
    gdci_host host (.mclk(mclk), .slow(slow), .tx(tx), .rx(rx), .tx_ready(tx_ready));
    // -----------------------------------------------------------------
    // Shared helpers
    // -----------------------------------------------------------------
    // Prints the counts and the verdict, then ends the run.
    task automatic summarize();
        $display("checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : summarize
    // Cuts a hang short.
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            summarize();
        end
    end
    // Presents a sample set, then a strobe rise with the set held stable.
    task automatic strobe_set(input gdci_samples_t s, input logic btn);
        @(negedge mclk);
        samples = s;
        user_button_two = btn;
        repeat (4) @(negedge mclk);
        sample_strobe = 1'b1;
        repeat (6) @(negedge mclk);
        sample_strobe = 1'b0;
    endtask : strobe_set
    // Waits, bounded, until the host has gathered n bytes.
    task automatic wait_n(input int n);
        for (int i = 0; i < 400 && host.got.size() < n; i++) @(negedge mclk);
    endtask : wait_n
    // Counts line feeds gathered so far.
    function automatic int n_lf();
        int c;
        c = 0;
        foreach (host.got[i]) if (host.got[i] === CH_LF) c++;
        return c;
    endfunction : n_lf
    // Three ASCII decimal digits of a byte, worked out independently.
    function automatic logic [23:0] dec(input logic [7:0] v);
        return {8'(8'h30 + v / 100), 8'(8'h30 + (v / 10) % 10), 8'(8'h30 + v % 10)};
    endfunction : dec
    // -----------------------------------------------------------------
    // Scenarios
    // -----------------------------------------------------------------
    // Binary frame: header, samples in order, zero pad, button bit.
    task automatic t_frame(input gdci_samples_t s, input logic btn);
        host.got.delete();
        strobe_set(s, btn);
        wait_n(FRAME_LEN);
        `CHK(host.got.size(), FRAME_LEN)
        `CHK(host.got[0], 8'h73)
        `CHK(host.got[1], 8'h74)
        for (int i = 0; i < 5; i++) `CHK(host.got[2 + i], s[39 - 8 * i -: 8])
        `CHK(host.got[7], 8'h00)
        `CHK(host.got[8], {7'h00, btn})
    endtask : t_frame
    // Nothing may come back within a generous window after a strobe.
    task automatic t_quiet();
        host.got.delete();
        strobe_set(40'h0102030405, 1'b1);
        repeat (30) @(negedge mclk);
        `CHK(host.got.size(), 0)
    endtask : t_quiet
    // Text streaming: five lines, each value as raw decimal after '='.
    task automatic t_debug(input gdci_samples_t s);
        int k;
        host.got.delete();
        strobe_set(s, 1'b0);
        for (int i = 0; i < 600 && n_lf() < 5; i++) @(negedge mclk);
        `CHK(n_lf(), 5)
        k = 0;
        foreach (host.got[i]) begin
            if (host.got[i] === CH_EQ && k < 5 && i + 3 < host.got.size()) begin
                `CHK({host.got[i + 1], host.got[i + 2], host.got[i + 3]},
                     dec(s[39 - 8 * k -: 8]))
                k++;
            end
        end
        `CHK(k, 5)
    endtask : t_debug
    // Identity reply: the parameter string without NUL bytes, up to LF.
    task automatic t_ident(input string cmd, input logic [8*REPLY_MAX-1:0] str);
        logic [7:0] exp[$];
        for (int i = REPLY_MAX - 1; i >= 0; i--) begin
            if (str[8 * i +: 8] !== 8'h00) exp.push_back(str[8 * i +: 8]);
        end
        host.got.delete();
        host.send_line(cmd);
        wait_n(exp.size());
        `CHK(host.got.size(), exp.size())
        foreach (exp[i]) `CHK(host.got[i], exp[i])
    endtask : t_ident
    // Mode outputs after a line has been taken.
    task automatic t_mode(input logic dig);
        `CHK(digital_working_mode, dig)
        `CHK(sensor_line_oe, {4{dig}})
    endtask : t_mode
    // -----------------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------------
    initial begin
        repeat (16) @(negedge mclk);
        srst = 1'b0;
        @(negedge mclk);
        `CHK(sensor_line_oe, 4'h0)
        `CHK(digital_working_mode, 1'b0)
        t_ident("*ver", VER_S);
        host.send_line("*Zoff");
        t_mode(1'b1);
        host.send_line("*bogus");
        t_mode(1'b1);
        t_quiet();
        host.send_line("*start");
        slow = 1'b1;
        t_frame(40'hc8_00_09_2d_ff, 1'b1);
        slow = 1'b0;
        t_frame(40'h01_80_7f_fe_10, 1'b0);
        host.send_line("xyz");
        t_frame(40'h55_aa_33_cc_0f, 1'b1);
        host.send_line("*stop");
        repeat (40) @(negedge mclk);
        t_quiet();
        host.send_line("*debug");
        t_debug(40'hc8_00_09_2d_ff);
        host.send_line("*stop");
        repeat (200) @(negedge mclk);
        t_quiet();
        t_ident("*dev", NAME_S);
        host.send_line("*Zon");
        `CHK(sensor_line_oe, 4'h0)
        t_mode(1'b0);
        t_ident("*dev", NAME_S);
        summarize();
    end
endmodule : tb_top
`default_nettype wire
